// ==== ccs_pkg.sv ====
// shared types, register layouts and constants of the charger control and status bank
// Behaviour
// - while the watchdog has expired, charge enable is held at zero
// - control bits 5-4 pick thermal limit 60/80/100/120 C; reset 3; watchdog restores
// - control bit 3 enables charging; cleared by register reset and watchdog expiry
// - bits 1-0 pick low-battery start threshold; watchdog expiry leaves it
// - control bits 7-6 and 2 always read zero
// - status bit 7 reads power good
// - status bit 6 reads input current regulation active
// - status bit 5 reads input voltage regulation active
// - status bit 4 reads thermal regulation active
// - status bit 3 latches watchdog expiry; expiry keeps it, register reset clears
// - status bits 2-0 give charge state: 0 idle, 3 constant current, 4 taper
// - after expiry four fault bits read zero until kick or period change
// - fault bit 7 reads input overvoltage protection
// - fault bit 6 reads thermal shutdown
// - fault bit 5 reads battery overvoltage
// - fault bit 4 reads flying capacitor fault
// - fault bit 2 reads capacitor precondition failure; bits 3 and 0 read zero
// - fault bit 1 sets after seven consecutive weak-source check failures
// - event flag register clears after being read; resets to zero
// - watchdog kick bit clears itself one cycle after it is set, one cycle before the timer restarts
// - watchdog period code: 0 off, then 40, 80, 160 seconds
// - a period write restarts the counter only when it changes the value
`default_nettype none
package ccs_pkg;
	// byte addresses on the serial bus
	localparam logic [7:0] OFS_CTRL1  = 8'h05;
	localparam logic [7:0] OFS_CTRL2  = 8'h06;
	localparam logic [7:0] OFS_OPSTAT = 8'h07;
	localparam logic [7:0] OFS_FAULT  = 8'h08;
	localparam logic [7:0] OFS_FLAGS  = 8'h09;
	localparam logic [7:0] CTRL1_RST  = 8'h9d;
	localparam logic [7:0] CTRL2_RST  = 8'h33;
	localparam logic [7:0] FLAGS_RST  = 8'h00;
	localparam logic [2:0] WEAK_SRC_LIMIT = 3'h7;
	localparam int CLK_PERIOD_NS = 10;
	localparam int NS_PER_S      = 1000000000;
	localparam int CYCLES_PER_S  = NS_PER_S / CLK_PERIOD_NS;
	localparam logic [7:0] WD_40_S  = 8'h28;
	localparam logic [7:0] WD_80_S  = 8'h50;
	localparam logic [7:0] WD_160_S = 8'ha0;

	typedef enum logic [1:0] {
		WD_OFF = 2'h0,
		WD_40  = 2'h1,
		WD_80  = 2'h2,
		WD_160 = 2'h3
	} ccs_wd_period_t;

	typedef struct packed {
		logic           term_enable;
		logic           watchdog_kick;
		ccs_wd_period_t wd_period;
		logic           safety_timer_en;
		logic [1:0]     safety_timer_sel;
		logic           timer_slow_en;
	} ccs_ctrl1_t;

	typedef struct packed {
		logic [1:0] rsv_hi;
		logic [1:0] thermal_limit_threshold;
		logic       charge_enable;
		logic       rsv_lo;
		logic [1:0] battery_low_threshold;
	} ccs_ctrl2_t;

	typedef struct packed {
		logic       power_good_status;
		logic       input_current_regulating;
		logic       input_voltage_regulating;
		logic       thermal_regulating;
		logic       watchdog_expired;
		logic [2:0] charge_state;
	} ccs_opstat_t;

	typedef struct packed {
		logic input_overvoltage;
		logic thermal_shutdown;
		logic battery_overvoltage;
		logic flying_cap_fault;
		logic rsv3;
		logic cap_precondition_fault;
		logic weak_source_fault;
		logic rsv0;
	} ccs_fault_t;

	typedef struct packed {
		logic power_good_toggled;
		logic input_current_rise;
		logic input_voltage_rise;
		logic thermal_rise;
		logic watchdog_rise;
		logic terminated_rise;
		logic rsv;
		logic charge_state_changed;
	} ccs_flags_t;

	// analog and charger-core indications, asynchronous to clock
	typedef struct packed {
		logic       power_good_status;
		logic       input_current_regulating;
		logic       input_voltage_regulating;
		logic       thermal_regulating;
		logic [2:0] charge_state;
		logic       input_overvoltage;
		logic       thermal_shutdown;
		logic       battery_overvoltage;
		logic       flying_cap_fault;
		logic       cap_precondition_fault;
		logic       weak_src_check_done;
		logic       weak_src_check_fail;
		logic       charge_terminated;
	} ccs_sense_t;

	function automatic logic [7:0] wd_limit_s(input ccs_wd_period_t p);
		unique case (p)
			WD_40:   wd_limit_s = WD_40_S;
			WD_80:   wd_limit_s = WD_80_S;
			WD_160:  wd_limit_s = WD_160_S;
			WD_OFF:  wd_limit_s = 8'h00;
		endcase
	endfunction : wd_limit_s
endpackage : ccs_pkg
`default_nettype wire

// ==== ccs_sync.sv ====
// two-flop synchroniser for a bundle of asynchronous levels
`default_nettype none
module ccs_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         clock,
	input  wire logic         arst_n,
	// levels
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} ccs_sync_st_t;

	ccs_sync_st_t s_r;
	ccs_sync_st_t s_nxt;

	always_comb
	begin
		s_nxt.s1 = d;
		s_nxt.s2 = s_r.s1;
	end

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign q = s_r.s2;
endmodule : ccs_sync
`default_nettype wire

// ==== ccs_watchdog.sv ====
// watchdog timer: one-second enable from a divider, expiry pulse at the period limit
`default_nettype none
module ccs_watchdog
	import ccs_pkg::*;
#(
	parameter int CYCLES_PER_SEC = CYCLES_PER_S
) (
	// clock and reset
	input  wire logic           clock,
	input  wire logic           arst_n,
	// control
	input  wire ccs_wd_period_t period,
	input  wire logic           restart,
	// event
	output logic                expire
);
	localparam int DIV_W = $clog2(CYCLES_PER_SEC);
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CYCLES_PER_SEC - 1);

	typedef struct packed {
		logic [DIV_W-1:0] div;
		logic [7:0]       secs;
		logic             halted;
		logic             expire;
	} ccs_wd_st_t;

	ccs_wd_st_t s_r;
	ccs_wd_st_t s_nxt;
	logic       tick;

	always_comb
	begin
		s_nxt = s_r;
		s_nxt.expire = 1'b0;
		tick = (s_r.div == DIV_LAST);
		s_nxt.div = tick ? '0 : s_r.div + 1'b1;
		if (restart || period == WD_OFF)
		begin
			s_nxt.div = '0;
			s_nxt.secs = 8'h00;
			s_nxt.halted = 1'b0;
		end
		else if (tick && !s_r.halted)
		begin
			// stops after one expiry so a stale period cannot fire again unasked
			if (s_r.secs + 8'h01 == wd_limit_s(period))
			begin
				s_nxt.expire = 1'b1;
				s_nxt.halted = 1'b1;
			end
			else
				s_nxt.secs = s_r.secs + 8'h01;
		end
	end

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign expire = s_r.expire;
endmodule : ccs_watchdog
`default_nettype wire

// ==== ccs_regs.sv ====
// charger control and status registers behind a serial two-wire target port
`default_nettype none
module ccs_regs
	import ccs_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = 7'h2a, // arbitrary bus address
	parameter int CYCLES_PER_SEC = CYCLES_PER_S
) (
	// clock and reset
	input  wire logic       clock,
	input  wire logic       arst_n,
	// serial bus, open drain
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe,
	// register reset command, same clock
	input  wire logic       reg_reset_req,
	// charger core indications
	input  wire ccs_sense_t sense,
	// settings to the charger core
	output logic            charge_enable,
	output logic [1:0]      thermal_limit_threshold,
	output logic [1:0]      battery_low_threshold,
	output logic            watchdog_expired
);
	typedef enum logic [2:0] {
		BUS_IDLE = 3'b000,
		BUS_ADDR = 3'b001,
		BUS_AACK = 3'b010,
		BUS_WDAT = 3'b011,
		BUS_WACK = 3'b100,
		BUS_RDAT = 3'b101,
		BUS_RACK = 3'b110
	} ccs_bus_t;

	typedef struct packed {
		ccs_bus_t    bus;
		logic [2:0]  cnt;
		logic [7:0]  shf;
		logic [7:0]  ptr;
		logic        have_ptr;
		logic        reading;
		logic        ack_seen;
		logic        host_ack;
		logic        scl_prev;
		logic        sda_prev;
		logic        sda_oe;
		logic        sda_out;
		ccs_ctrl1_t  ctrl1;
		ccs_ctrl2_t  ctrl2;
		logic        wd_expired;
		logic        fault_hold;
		logic        wd_restart;
		ccs_flags_t  flags;
		logic [2:0]  weak_cnt;
		ccs_sense_t  sense_prev;
		logic        wd_prev;
	} ccs_st_t;

	ccs_st_t     s_r;
	ccs_st_t     s_nxt;
	ccs_sense_t  sn;
	logic [1:0]  pins;
	logic        scl;
	logic        sda;
	logic        wd_expire;
	logic        scl_rise;
	logic        scl_fall;
	logic        start_c;
	logic        stop_c;
	logic        wr_en;
	logic [7:0]  wr_data;
	logic        rd_en;
	logic [7:0]  rd_data;
	ccs_opstat_t op;
	ccs_fault_t  ft;
	ccs_flags_t  ev;
	ccs_ctrl1_t  w1;
	ccs_ctrl2_t  w2;

	ccs_sync #(
		.W($bits(ccs_sense_t))
	) u_sense_sync (
		.clock  (clock),
		.arst_n (arst_n),
		.d      (sense),
		.q      (sn)
	);

	ccs_sync #(
		.W(2)
	) u_pin_sync (
		.clock  (clock),
		.arst_n (arst_n),
		.d      ({~scl_in, ~sda_in}),
		.q      (pins)
	);

	ccs_watchdog #(
		.CYCLES_PER_SEC(CYCLES_PER_SEC)
	) u_wd (
		.clock   (clock),
		.arst_n  (arst_n),
		.period  (s_r.ctrl1.wd_period),
		.restart (s_r.wd_restart),
		.expire  (wd_expire)
	);

	// pins pass inverted so a cleared synchroniser reads as an idle high bus, no false edge after reset
	assign scl = ~pins[1];
	assign sda = ~pins[0];

	// status views, built live from the synchronised indications
	always_comb
	begin
		op = '0;
		op.power_good_status = sn.power_good_status;
		op.input_current_regulating = sn.input_current_regulating;
		op.input_voltage_regulating = sn.input_voltage_regulating;
		op.thermal_regulating = sn.thermal_regulating;
		op.watchdog_expired = s_r.wd_expired;
		op.charge_state = sn.charge_state;
		ft = '0;
		ft.input_overvoltage = sn.input_overvoltage & ~s_r.fault_hold;
		ft.thermal_shutdown = sn.thermal_shutdown & ~s_r.fault_hold;
		ft.battery_overvoltage = sn.battery_overvoltage & ~s_r.fault_hold;
		ft.flying_cap_fault = sn.flying_cap_fault & ~s_r.fault_hold;
		ft.cap_precondition_fault = sn.cap_precondition_fault;
		ft.weak_source_fault = (s_r.weak_cnt == WEAK_SRC_LIMIT);
		rd_data = 8'h00;
		unique case (s_r.ptr)
			OFS_CTRL1:  rd_data = s_r.ctrl1;
			OFS_CTRL2:  rd_data = s_r.ctrl2;
			OFS_OPSTAT: rd_data = op;
			OFS_FAULT:  rd_data = ft;
			OFS_FLAGS:  rd_data = s_r.flags;
			default:    rd_data = 8'h00;
		endcase
	end

	// serial target: sample on scl rise, change sda on scl fall
	always_comb
	begin
		s_nxt = s_r;
		wr_en = 1'b0;
		rd_en = 1'b0;
		wr_data = {s_r.shf[6:0], sda};
		s_nxt.scl_prev = scl;
		s_nxt.sda_prev = sda;
		s_nxt.sda_out = 1'b0;
		scl_rise = scl & ~s_r.scl_prev;
		scl_fall = ~scl & s_r.scl_prev;
		start_c = scl & s_r.scl_prev & ~sda & s_r.sda_prev;
		stop_c = scl & s_r.scl_prev & sda & ~s_r.sda_prev;
		if (start_c)
		begin
			s_nxt.bus = BUS_ADDR;
			s_nxt.cnt = 3'h0;
			s_nxt.have_ptr = 1'b0;
			s_nxt.sda_oe = 1'b0;
		end
		else if (stop_c)
		begin
			s_nxt.bus = BUS_IDLE;
			s_nxt.sda_oe = 1'b0;
		end
		else
		begin
			unique case (s_r.bus)
				BUS_IDLE: s_nxt.sda_oe = 1'b0;
				BUS_ADDR:
					if (scl_rise)
					begin
						s_nxt.shf = wr_data;
						s_nxt.cnt = s_r.cnt + 3'h1;
						if (s_r.cnt == 3'h7)
						begin
							s_nxt.reading = sda;
							s_nxt.bus = (wr_data[7:1] == DEV_ADDR) ? BUS_AACK : BUS_IDLE;
						end
					end
				BUS_AACK, BUS_WACK:
					if (scl_fall)
					begin
						s_nxt.sda_oe = ~s_r.sda_oe;
						if (s_r.sda_oe && s_r.bus == BUS_AACK && s_r.reading)
						begin
							rd_en = 1'b1;
							s_nxt.shf = rd_data;
							s_nxt.sda_oe = ~rd_data[7];
							s_nxt.ptr = s_r.ptr + 8'h01;
							s_nxt.bus = BUS_RDAT;
						end
						else if (s_r.sda_oe)
							s_nxt.bus = BUS_WDAT;
					end
				BUS_WDAT:
					if (scl_rise)
					begin
						s_nxt.shf = wr_data;
						s_nxt.cnt = s_r.cnt + 3'h1;
						if (s_r.cnt == 3'h7)
						begin
							s_nxt.bus = BUS_WACK;
							s_nxt.have_ptr = 1'b1;
							if (!s_r.have_ptr)
								s_nxt.ptr = wr_data;
							else
							begin
								wr_en = 1'b1;
								s_nxt.ptr = s_r.ptr + 8'h01;
							end
						end
					end
				BUS_RDAT:
					if (scl_rise)
					begin
						s_nxt.cnt = s_r.cnt + 3'h1;
						if (s_r.cnt == 3'h7)
						begin
							s_nxt.bus = BUS_RACK;
							s_nxt.ack_seen = 1'b0;
						end
					end
					else if (scl_fall)
					begin
						s_nxt.shf = {s_r.shf[6:0], 1'b0};
						s_nxt.sda_oe = ~s_r.shf[6];
					end
				BUS_RACK:
					if (scl_rise)
					begin
						s_nxt.ack_seen = 1'b1;
						s_nxt.host_ack = ~sda;
					end
					else if (scl_fall && !s_r.ack_seen)
						s_nxt.sda_oe = 1'b0;
					else if (scl_fall && s_r.host_ack)
					begin
						rd_en = 1'b1;
						s_nxt.shf = rd_data;
						s_nxt.sda_oe = ~rd_data[7];
						s_nxt.ptr = s_r.ptr + 8'h01;
						s_nxt.bus = BUS_RDAT;
					end
					else if (scl_fall)
						s_nxt.bus = BUS_IDLE;
				default: s_nxt.bus = BUS_IDLE;
			endcase
		end

		// register writes, status and flag writes fall through untouched
		w1 = ccs_ctrl1_t'(wr_data);
		w2 = ccs_ctrl2_t'(wr_data);
		s_nxt.wd_restart = s_r.ctrl1.watchdog_kick | reg_reset_req;
		if (s_r.ctrl1.watchdog_kick)
		begin
			s_nxt.ctrl1.watchdog_kick = 1'b0;
			s_nxt.fault_hold = 1'b0;
			s_nxt.wd_expired = 1'b0;
		end
		if (wr_en && s_r.ptr == OFS_CTRL1)
		begin
			s_nxt.ctrl1 = w1;
			if (w1.wd_period != s_r.ctrl1.wd_period)
			begin
				s_nxt.wd_restart = 1'b1;
				s_nxt.fault_hold = 1'b0;
				s_nxt.wd_expired = 1'b0;
			end
		end
		if (wr_en && s_r.ptr == OFS_CTRL2)
		begin
			s_nxt.ctrl2 = w2;
			s_nxt.ctrl2.rsv_hi = 2'h0;
			s_nxt.ctrl2.rsv_lo = 1'b0;
		end

		// watchdog expiry restores its fields but keeps the low-battery threshold
		if (wd_expire)
		begin
			s_nxt.ctrl1 = ccs_ctrl1_t'(CTRL1_RST);
			s_nxt.ctrl2 = ccs_ctrl2_t'(CTRL2_RST);
			s_nxt.ctrl2.charge_enable = 1'b0;
			s_nxt.ctrl2.battery_low_threshold = s_r.ctrl2.battery_low_threshold;
			s_nxt.wd_expired = 1'b1;
			s_nxt.fault_hold = 1'b1;
		end

		// weak-source check: count consecutive failures, saturate at the limit
		s_nxt.sense_prev = sn;
		if (sn.weak_src_check_done && !s_r.sense_prev.weak_src_check_done)
		begin
			if (!sn.weak_src_check_fail)
				s_nxt.weak_cnt = 3'h0;
			else if (s_r.weak_cnt != WEAK_SRC_LIMIT)
				s_nxt.weak_cnt = s_r.weak_cnt + 3'h1;
		end

		// event flags: a new event in the read cycle survives the clear
		s_nxt.wd_prev = s_r.wd_expired;
		ev = '0;
		ev.power_good_toggled = sn.power_good_status ^ s_r.sense_prev.power_good_status;
		ev.input_current_rise = sn.input_current_regulating & ~s_r.sense_prev.input_current_regulating;
		ev.input_voltage_rise = sn.input_voltage_regulating & ~s_r.sense_prev.input_voltage_regulating;
		ev.thermal_rise = sn.thermal_regulating & ~s_r.sense_prev.thermal_regulating;
		ev.watchdog_rise = s_r.wd_expired & ~s_r.wd_prev;
		ev.terminated_rise = sn.charge_terminated & ~s_r.sense_prev.charge_terminated;
		ev.charge_state_changed = (sn.charge_state != s_r.sense_prev.charge_state);
		if (rd_en && s_r.ptr == OFS_FLAGS)
			s_nxt.flags = ev;
		else
			s_nxt.flags = s_r.flags | ev;

		if (reg_reset_req)
		begin
			s_nxt.ctrl1 = ccs_ctrl1_t'(CTRL1_RST);
			s_nxt.ctrl2 = ccs_ctrl2_t'(CTRL2_RST);
			s_nxt.wd_expired = 1'b0;
			s_nxt.fault_hold = 1'b0;
			s_nxt.weak_cnt = 3'h0;
			s_nxt.flags = ccs_flags_t'(FLAGS_RST);
		end

		// expired state wins over any write of the enable bit
		if (s_nxt.wd_expired)
			s_nxt.ctrl2.charge_enable = 1'b0;
	end

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			s_r <= '0;
			s_r.scl_prev <= 1'b1;
			s_r.sda_prev <= 1'b1;
			s_r.ctrl1 <= ccs_ctrl1_t'(CTRL1_RST);
			s_r.ctrl2 <= ccs_ctrl2_t'(CTRL2_RST);
			s_r.flags <= ccs_flags_t'(FLAGS_RST);
		end
		else
			s_r <= s_nxt;
	end

	assign sda_out = s_r.sda_out;
	assign sda_oe = s_r.sda_oe;
	assign charge_enable = s_r.ctrl2.charge_enable;
	assign thermal_limit_threshold = s_r.ctrl2.thermal_limit_threshold;
	assign battery_low_threshold = s_r.ctrl2.battery_low_threshold;
	assign watchdog_expired = s_r.wd_expired;
endmodule : ccs_regs
`default_nettype wire

// ==== ccs_regs_monitor.sv ====
// assertion checker bound to the charger control and status register bank
`default_nettype none
module ccs_regs_monitor
	import ccs_pkg::*;
(
	// clock and reset
	input wire logic       clock,
	input wire logic       arst_n,
	// serial bus
	input wire logic       scl_in,
	input wire logic       sda_in,
	input wire logic       sda_out,
	input wire logic       sda_oe,
	// command and indications
	input wire logic       reg_reset_req,
	input wire ccs_sense_t sense,
	// settings
	input wire logic       charge_enable,
	input wire logic [1:0] thermal_limit_threshold,
	input wire logic [1:0] battery_low_threshold,
	input wire logic       watchdog_expired
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!arst_n);

	a_enable_held_low: assert property (watchdog_expired && $past(watchdog_expired) |-> !charge_enable)
		else $error("charge enable high while watchdog expired");
	a_enable_rise_src: assert property ($rose(charge_enable) |-> scl_in && !watchdog_expired)
		else $error("charge enable rose without a host write");
	a_reg_reset_vals: assert property (reg_reset_req |=> thermal_limit_threshold == 2'h3 && !charge_enable
		&& battery_low_threshold == 2'h3 && !watchdog_expired)
		else $error("register reset left a setting off its reset value");
	a_expiry_restore: assert property ($rose(watchdog_expired) |-> ##[0:1] (thermal_limit_threshold == 2'h3
		&& !charge_enable))
		else $error("expiry did not restore thermal limit and enable");
	a_expiry_keeps_low: assert property ($rose(watchdog_expired) |-> $stable(battery_low_threshold))
		else $error("expiry changed the low battery threshold");
	a_low_thr_source: assert property ($changed(battery_low_threshold) |-> scl_in || $past(reg_reset_req))
		else $error("low battery threshold changed outside a write");
	a_tlim_source: assert property ($changed(thermal_limit_threshold) |-> scl_in || $past(reg_reset_req)
		|| watchdog_expired)
		else $error("thermal limit changed outside a write or expiry");
	a_expired_clear: assert property ($fell(watchdog_expired) |-> scl_in || $past(reg_reset_req))
		else $error("watchdog expired flag cleared on its own");
	a_ack_on_low: assert property ($changed(sda_oe) |-> !scl_in)
		else $error("data line driver changed while clock high");

	c_expiry: cover property ($rose(watchdog_expired));
	c_enable: cover property ($rose(charge_enable));
	c_ack: cover property ($rose(sda_oe));
	c_reg_reset: cover property (reg_reset_req);
endmodule : ccs_regs_monitor

bind ccs_regs ccs_regs_monitor i_ccs_regs_monitor (.clock(clock), .arst_n(arst_n), .scl_in(scl_in),
	.sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .reg_reset_req(reg_reset_req), .sense(sense),
	.charge_enable(charge_enable), .thermal_limit_threshold(thermal_limit_threshold),
	.battery_low_threshold(battery_low_threshold), .watchdog_expired(watchdog_expired));
`default_nettype wire

// ==== ccs_host.sv ====
// serial bus host model that reaches the register bank
`default_nettype none
module ccs_host
	import ccs_pkg::*;
#(
	parameter logic [6:0] ADDR = 7'h2a,
	parameter int         H    = 8
) (
	// clock
	input  wire logic clock,
	// bus
	input  wire logic sda,
	output var logic  scl,
	output var logic  sda_low,
	// status
	output var logic  ack_ok
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		scl = 1'b1;
		sda_low = 1'b0;
		ack_ok = 1'b1;
	end
	// data only moves in its own step while the clock is low, so no false start or stop
	task automatic step(input logic c, input logic l);
		scl <= c;
		sda_low <= l;
		repeat (H) @(posedge clock);
	endtask : step
	task automatic bitx(input logic b, output logic r);
		step(1'b0, sda_low);
		step(1'b0, !b);
		step(1'b1, !b);
		r = sda;
	endtask : bitx
	task automatic start;
		step(1'b0, sda_low);
		step(1'b0, 1'b0);
		step(1'b1, 1'b0);
		step(1'b1, 1'b1);
	endtask : start
	task automatic stop;
		step(1'b0, sda_low);
		step(1'b0, 1'b1);
		step(1'b1, 1'b1);
		step(1'b1, 1'b0);
	endtask : stop
	task automatic wbyte(input logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
			bitx(d[i], r);
		bitx(1'b1, r);
		if (r !== 1'b0)
			ack_ok = 1'b0;
	endtask : wbyte
	task automatic reg_wr(input logic [7:0] p, input logic [7:0] d);
		start();
		wbyte({ADDR, 1'b0});
		wbyte(p);
		wbyte(d);
		stop();
	endtask : reg_wr
	task automatic reg_rd(input logic [7:0] p, output logic [7:0] q);
		logic r;
		start();
		wbyte({ADDR, 1'b0});
		wbyte(p);
		start();
		wbyte({ADDR, 1'b1});
		for (int i = 7; i >= 0; i--)
			bitx(1'b1, q[i]);
		bitx(1'b1, r);
		stop();
	endtask : reg_rd
endmodule : ccs_host
`default_nettype wire

// ==== tb_top.sv ====
// self-checking bench for the charger control and status register bank
`default_nettype none
module tb_top
	import ccs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// shortened second keeps the watchdog periods within the run
	localparam int CPS  = 100;
	localparam int TMAX = 60000;
	logic       clock;
	logic       arst_n;
	logic       reg_reset_req;
	ccs_sense_t sense;
	wire logic  scl;
	wire logic  sda;
	wire logic  sda_low;
	wire logic  sda_oe;
	wire logic  sda_out;
	wire logic  ack_ok;
	wire logic  charge_enable;
	wire logic  watchdog_expired;
	wire logic [1:0] tl;
	wire logic [1:0] bl;
	int         n_fail = 0;
	int         tests_run = 0;
	int         cyc = 0;
	logic [7:0] q;
	logic [7:0] v;
	logic       wd_m;
	logic       weak_m;
	logic [2:0] cs_tab [3] = '{3'h0, 3'h3, 3'h4};

	// pull-up on the data line
	assign sda = !(sda_low || sda_oe);

	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	ccs_regs #(.DEV_ADDR(7'h2a), .CYCLES_PER_SEC(CPS)) i_ccs_regs (.clock(clock), .arst_n(arst_n), .scl_in(scl),
		.sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .reg_reset_req(reg_reset_req), .sense(sense),
		.charge_enable(charge_enable), .thermal_limit_threshold(tl), .battery_low_threshold(bl),
		.watchdog_expired(watchdog_expired));
	ccs_host #(.ADDR(7'h2a), .H(8)) i_ccs_host (.clock(clock), .sda(sda), .scl(scl), .sda_low(sda_low),
		.ack_ok(ack_ok));

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic results;
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : results
	task automatic rd(input logic [7:0] p, input logic [7:0] e);
		i_ccs_host.reg_rd(p, q);
		check(q, e);
	endtask : rd
	function automatic logic [7:0] st_exp();
		st_exp = {sense.power_good_status, sense.input_current_regulating, sense.input_voltage_regulating,
			sense.thermal_regulating, wd_m, sense.charge_state};
	endfunction : st_exp
	function automatic logic [7:0] flt_exp();
		flt_exp = {wd_m ? 4'h0 : {sense.input_overvoltage, sense.thermal_shutdown, sense.battery_overvoltage,
			sense.flying_cap_fault}, 1'b0, sense.cap_precondition_fault, weak_m, 1'b0};
	endfunction : flt_exp
	task automatic rand_sense;
		ccs_sense_t  s;
		logic [31:0] r;
		r = $urandom;
		s = r[$bits(ccs_sense_t)-1:0];
		s.charge_state = cs_tab[$urandom % 3];
		s.weak_src_check_done = 1'b0;
		s.weak_src_check_fail = 1'b0;
		sense <= s;
		repeat (4) @(posedge clock);
	endtask : rand_sense
	task automatic pulse(input logic f);
		sense.weak_src_check_fail <= f;
		repeat (4) @(posedge clock);
		sense.weak_src_check_done <= 1'b1;
		repeat (4) @(posedge clock);
		sense.weak_src_check_done <= 1'b0;
		repeat (4) @(posedge clock);
	endtask : pulse

	always @(posedge clock)
	begin
		cyc <= cyc + 1;
		if (cyc == TMAX)
		begin
			n_fail++;
			results();
		end
	end

	initial
	begin
		arst_n = 1'b0;
		reg_reset_req = 1'b0;
		sense = '0;
		wd_m = 1'b0;
		weak_m = 1'b0;
		void'($urandom(55));
		repeat (10) @(posedge clock);
		arst_n <= 1'b1;
		repeat (4) @(posedge clock);
		// watchdog off while the static checks run
		i_ccs_host.reg_wr(OFS_CTRL1, 8'h8d);
		rd(OFS_CTRL2, CTRL2_RST);
		rd(OFS_FLAGS, FLAGS_RST);
		for (int i = 0; i < 4; i++)
		begin
			rand_sense();
			rd(OFS_OPSTAT, st_exp());
			i_ccs_host.reg_wr(OFS_FAULT, 8'hff);
			rd(OFS_FAULT, flt_exp());
			v = 8'($urandom);
			v[5:4] = 2'(i);
			i_ccs_host.reg_wr(OFS_CTRL2, v);
			rd(OFS_CTRL2, v & 8'h3b);
			check({2'h0, tl, charge_enable, 1'b0, bl}, v & 8'h3b);
		end
		check({7'h0, watchdog_expired}, 8'h00);
		i_ccs_host.reg_rd(OFS_FLAGS, q);
		sense.power_good_status <= !sense.power_good_status;
		repeat (4) @(posedge clock);
		rd(OFS_FLAGS, 8'h80);
		rd(OFS_FLAGS, 8'h00);
		for (int i = 0; i < 8; i++)
		begin
			pulse(i < 7);
			weak_m = (i == 6);
			if (i >= 5)
				rd(OFS_FAULT, flt_exp());
		end
		rand_sense();
		// faults present, so the hold after expiry has something to mask
		{sense.input_overvoltage, sense.thermal_shutdown, sense.battery_overvoltage, sense.flying_cap_fault} <= 4'hf;
		i_ccs_host.reg_wr(OFS_CTRL2, 8'h1a);
		i_ccs_host.reg_wr(OFS_CTRL1, 8'h9d);
		repeat (1500) @(posedge clock);
		i_ccs_host.reg_wr(OFS_CTRL1, 8'h9d);
		repeat (1600) @(posedge clock);
		check({7'h0, watchdog_expired}, 8'h00);
		repeat (400) @(posedge clock);
		check({7'h0, watchdog_expired}, 8'h01);
		wd_m = 1'b1;
		rd(OFS_CTRL2, 8'h32);
		rd(OFS_OPSTAT, st_exp());
		rd(OFS_FAULT, flt_exp());
		i_ccs_host.reg_wr(OFS_CTRL2, 8'h1a);
		check({7'h0, charge_enable}, 8'h00);
		i_ccs_host.reg_wr(OFS_CTRL1, 8'hdd);
		wd_m = 1'b0;
		rd(OFS_CTRL1, 8'h9d);
		rd(OFS_FAULT, flt_exp());
		i_ccs_host.reg_wr(OFS_CTRL2, 8'h1a);
		check({7'h0, charge_enable}, 8'h01);
		reg_reset_req <= 1'b1;
		@(posedge clock);
		reg_reset_req <= 1'b0;
		@(posedge clock);
		check({2'h0, tl, charge_enable, 1'b0, bl}, CTRL2_RST);
		rd(OFS_FLAGS, FLAGS_RST);
		check({7'h0, ack_ok}, 8'h01);
		check({7'h0, sda_out}, 8'h00);
		results();
	end
endmodule : tb_top
`default_nettype wire
